// file: rtl/bpcs_pkg.sv
package bpcs_pkg;

   localparam int unsigned CNT_W      = 32;
   localparam int unsigned FIFO_DEPTH = 16;
   localparam int unsigned FIFO_AW    = 4;

   // Timebase chain, fastest timebase is CLK itself
   localparam int unsigned FAST_TB_HZ = 80_000_000;
   localparam int unsigned MID_TB_HZ  = 20_000_000;
   localparam int unsigned SLOW_TB_HZ = 100_000;
   localparam int unsigned MID_DIV    = FAST_TB_HZ / MID_TB_HZ;
   localparam int unsigned SLOW_DIV   = MID_TB_HZ / SLOW_TB_HZ;

   localparam logic [1:0] MID_CNT_LAST  = 2'(MID_DIV - 1);
   localparam logic [7:0] SLOW_CNT_LAST = 8'(SLOW_DIV - 1);
   localparam logic [1:0] MID_CNT_RST   = 2'h0;
   localparam logic [7:0] SLOW_CNT_RST  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
   localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

   typedef enum logic [1:0] {
      BPCS_SRC_EXT,
      BPCS_SRC_FAST,
      BPCS_SRC_MID,
      BPCS_SRC_SLOW
   } bpcs_src_t;

   // Enables of the derived timebases, one-cycle pulses
   typedef struct packed {
      logic mid;
      logic slow;
   } bpcs_tb_t;

   // One measurement handed to the buffer
   typedef struct packed {
      logic [CNT_W-1:0] count;
   } bpcs_meas_t;

endpackage

// file: rtl/bpcs_fifo.sv
`timescale 1ns/1ps
module bpcs_fifo #(
   parameter int unsigned WIDTH = 32,
   parameter int unsigned DEPTH = 16,
   parameter int unsigned AW    = 4
) (
   // Clock and reset
   input  wire logic             CLK,
   input  wire logic             NRST,
   // Fill side
   input  wire logic             IN_VALID,
   output      logic             IN_READY,
   input  wire logic [WIDTH-1:0] IN_DATA,
   // Drain side
   output      logic             OUT_VALID,
   input  wire logic             OUT_READY,
   output      logic [WIDTH-1:0] OUT_DATA
);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } fifo_st_t;

   fifo_st_t s;
   fifo_st_t next_s;
   logic     push;
   logic     pop;

   assign IN_READY  = (s.cnt != (AW+1)'(DEPTH));
   assign OUT_VALID = (s.cnt != '0);
   assign OUT_DATA  = s.mem[s.rd];
   assign push      = IN_VALID & IN_READY;
   assign pop       = OUT_VALID & OUT_READY;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wr] = IN_DATA;
         next_s.wr        = AW'((s.wr + 1'b1) % DEPTH);
      end
      if (pop) begin
         next_s.rd = AW'((s.rd + 1'b1) % DEPTH);
      end
      next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// file: rtl/bpcs_top.sv
`timescale 1ns/1ps
module bpcs_top
   import bpcs_pkg::*;
(
   // Clock (fastest timebase) and reset
   input  wire logic             CLK,
   input  wire logic             NRST,
   // Terminals
   input  wire logic             GATE_IN,
   input  wire logic             SOURCE_IN,
   // Static configuration
   input  wire bpcs_src_t        SRC_SEL,
   input  wire logic             AIAO_SLOW_SEL,
   // Timebase enables
   output      bpcs_tb_t         TB_EN,
   output      logic             AIAO_TB_EN,
   // Counter state
   output      logic [CNT_W-1:0] COUNT,
   output      logic             INT_OUT,
   output      logic             OVERRUN,
   // Measurement stream
   output      logic             M_VALID,
   input  wire logic             M_READY,
   output      bpcs_meas_t       M_DATA
);
   typedef struct packed {
      logic             g_s1;
      logic             g_s2;
      logic             g_d;
      logic             x_s1;
      logic             x_s2;
      logic             x_d;
      logic [1:0]       mid_cnt;
      logic [7:0]       slow_cnt;
      logic [CNT_W-1:0] per_cnt;
      logic [CNT_W-1:0] total;
      logic             int_out;
      logic             overrun;
   } top_st_t;

   top_st_t    s;
   top_st_t    next_s;
   logic       gate_rise;
   logic       ext_rise;
   logic       mid_en;
   logic       slow_en;
   logic       src_edge;
   logic       fifo_in_ready;
   bpcs_meas_t fifo_in_data;

   // Edge detectors read only the second synchroniser stage
   assign gate_rise = s.g_s2 & ~s.g_d;
   assign ext_rise  = s.x_s2 & ~s.x_d;

   // Fixed phase: mid enable fires when the divide-by-4 counter wraps
   assign mid_en  = (s.mid_cnt == MID_CNT_LAST);
   assign slow_en = mid_en & (s.slow_cnt == SLOW_CNT_LAST);

   // Counter source select; internal timebases need no synchroniser
   always_comb begin
      case (SRC_SEL)
         BPCS_SRC_EXT:  src_edge = ext_rise;
         BPCS_SRC_FAST: src_edge = 1'b1;
         BPCS_SRC_MID:  src_edge = mid_en;
         BPCS_SRC_SLOW: src_edge = slow_en;
         default:       src_edge = 1'b0;
      endcase
   end

   assign TB_EN.mid  = mid_en;
   assign TB_EN.slow = slow_en;
   assign AIAO_TB_EN = AIAO_SLOW_SEL ? slow_en : mid_en;

   // Gate edge written straight from the fast-timebase detector, never held to a source edge
   assign fifo_in_data.count = s.per_cnt;

   always_comb begin
      next_s        = s;
      // Both terminals synchronised to CLK before any edge logic
      next_s.g_s1   = GATE_IN;
      next_s.g_s2   = s.g_s1;
      next_s.g_d    = s.g_s2;
      next_s.x_s1   = SOURCE_IN;
      next_s.x_s2   = s.x_s1;
      next_s.x_d    = s.x_s2;
      next_s.mid_cnt = (mid_en) ? MID_CNT_RST : 2'(s.mid_cnt + 1'b1);
      if (mid_en) begin
         next_s.slow_cnt = (s.slow_cnt == SLOW_CNT_LAST) ? SLOW_CNT_RST
                                                         : 8'(s.slow_cnt + 1'b1);
      end
      // A source edge coinciding with a gate edge opens the new period
      if (gate_rise) begin
         next_s.per_cnt = src_edge ? CNT_ONE : CNT_RST;
      end else if (src_edge) begin
         next_s.per_cnt = s.per_cnt + CNT_ONE;
      end
      if (src_edge) begin
         next_s.total   = s.total + CNT_ONE;
      end
      // Internal output toggles on counter wrap, in the CLK domain
      next_s.int_out = (src_edge && (s.total == '1)) ? ~s.int_out : s.int_out;
      // Buffer full at a gate edge loses that measurement; flag for one cycle
      next_s.overrun = gate_rise & ~fifo_in_ready;
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign COUNT   = s.total;
   assign INT_OUT = s.int_out;
   assign OVERRUN = s.overrun;

   bpcs_fifo #(
      .WIDTH (CNT_W),
      .DEPTH (FIFO_DEPTH),
      .AW    (FIFO_AW)
   ) u_fifo (
      .CLK       (CLK),
      .NRST      (NRST),
      .IN_VALID  (gate_rise),
      .IN_READY  (fifo_in_ready),
      .IN_DATA   (fifo_in_data),
      .OUT_VALID (M_VALID),
      .OUT_READY (M_READY),
      .OUT_DATA  (M_DATA)
   );

   // Checks
   chk_gate_write: assert property (@(posedge CLK) disable iff (!NRST)
      gate_rise && fifo_in_ready |=> M_VALID)
      else $error("gate edge did not reach the buffer");

   chk_period_value: assert property (@(posedge CLK) disable iff (!NRST)
      gate_rise |=> s.per_cnt == ($past(src_edge) ? CNT_ONE : CNT_RST))
      else $error("period count not restarted at gate edge");

   chk_gate_sync: assert property (@(posedge CLK) disable iff (!NRST)
      $rose(s.g_s1) |=> gate_rise)
      else $error("gate edge not seen two cycles after capture");

   chk_zero_store: assert property (@(posedge CLK) disable iff (!NRST)
      gate_rise ##1 (!src_edge && !gate_rise)[*2] ##1 gate_rise |-> fifo_in_data.count == CNT_RST)
      else $error("empty period not stored as zero");

   chk_single_inc: assert property (@(posedge CLK) disable iff (!NRST)
      src_edge && !gate_rise |=> s.per_cnt == $past(s.per_cnt) + CNT_ONE)
      else $error("period count did not step by one");

   chk_long_pulse: assert property (@(posedge CLK) disable iff (!NRST)
      ext_rise |=> !ext_rise)
      else $error("one source pulse gave two edges");

   chk_total_step: assert property (@(posedge CLK) disable iff (!NRST)
      COUNT == $past(COUNT) + ($past(src_edge) ? CNT_ONE : CNT_RST))
      else $error("count moved without a source edge");

   chk_fast_source: assert property (@(posedge CLK) disable iff (!NRST)
      SRC_SEL == BPCS_SRC_FAST |-> src_edge)
      else $error("fast timebase not counted every cycle");

   chk_mid_period: assert property (@(posedge CLK) disable iff (!NRST)
      mid_en |=> !mid_en[*3] ##1 mid_en)
      else $error("mid timebase not one in four");

   chk_slow_on_mid: assert property (@(posedge CLK) disable iff (!NRST)
      slow_en |-> mid_en && s.slow_cnt == SLOW_CNT_LAST)
      else $error("slow timebase out of phase");

   chk_aiao_origin: assert property (@(posedge CLK) disable iff (!NRST)
      AIAO_TB_EN == (AIAO_SLOW_SEL ? TB_EN.slow : TB_EN.mid))
      else $error("analog timing origin wrong");

   cov_zero_period: cover property (@(posedge CLK) disable iff (!NRST)
      gate_rise && fifo_in_data.count == CNT_RST);
   cov_ext_count: cover property (@(posedge CLK) disable iff (!NRST)
      SRC_SEL == BPCS_SRC_EXT && ext_rise ##[1:50] gate_rise);
   cov_overrun: cover property (@(posedge CLK) disable iff (!NRST) OVERRUN);
endmodule

// file: dv/bpcs_term_model.sv
`timescale 1ns/1ps
module bpcs_term_model (
   // Clock
   input  wire logic CLK,
   // Terminals
   output      logic GATE,
   output      logic SRC
);
   initial begin
      GATE = 1'b0;
      SRC  = 1'b0;
   end

   // Edges land on falling edges so the synchroniser never sees a race
   task automatic src_pulses(input int n, input int hi);
      for (int i = 0; i < n; i++) begin
         @(negedge CLK) SRC = 1'b1;
         repeat (hi) @(negedge CLK);
         SRC = 1'b0;
         repeat (2) @(negedge CLK);
      end
   endtask

   // Rising edges of back-to-back calls are hi + lo + 1 cycles apart
   task automatic gate_pulse(input int hi, input int lo);
      @(negedge CLK) GATE = 1'b1;
      repeat (hi) @(negedge CLK);
      GATE = 1'b0;
      repeat (lo) @(negedge CLK);
   endtask
endmodule

// file: dv/test_buffered_period_counter_sync.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end

module test_buffered_period_counter_sync;
   import bpcs_pkg::*;
   typedef struct {int n; int hi;} bpcs_row_t;
   typedef struct {bpcs_src_t s; int per; int exp;} bpcs_int_t;
   logic             clk = 1'b0;
   logic             nrst = 1'b0;
   logic             m_ready = 1'b0;
   logic             aiao_slow_sel = 1'b0;
   bpcs_src_t        src_sel = BPCS_SRC_EXT;
   wire logic        gate;
   wire logic        src;
   bpcs_tb_t         tb_en;
   logic             aiao_tb_en;
   logic [CNT_W-1:0] count;
   logic             int_out;
   logic             overrun;
   logic             m_valid;
   bpcs_meas_t       m_data;
   int               err_total = 0;
   int               n_compared = 0;
   int               n_ovr = 0;
   int               nm, ns, na;
   bpcs_row_t        rows[4] = '{'{0, 1}, '{3, 1}, '{2, 9}, '{5, 2}};
   bpcs_int_t        irows[3] = '{'{BPCS_SRC_FAST, 10, 10}, '{BPCS_SRC_MID, 40, 10},
                                  '{BPCS_SRC_SLOW, 1600, 2}};

   always #12.5 clk = ~clk;
   always @(negedge clk) if (overrun === 1'b1) n_ovr++;

   bpcs_top bpcs_top_inst (.CLK(clk), .NRST(nrst), .GATE_IN(gate), .SOURCE_IN(src),
      .SRC_SEL(src_sel), .AIAO_SLOW_SEL(aiao_slow_sel), .TB_EN(tb_en),
      .AIAO_TB_EN(aiao_tb_en), .COUNT(count), .INT_OUT(int_out), .OVERRUN(overrun),
      .M_VALID(m_valid), .M_READY(m_ready), .M_DATA(m_data));
   bpcs_term_model bpcs_term_model_inst (.CLK(clk), .GATE(gate), .SRC(src));

   task automatic end_sim;
      if (err_total == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Waits for a stored word, optionally compares it, then pops it
   task automatic pop(input logic chk, input logic [CNT_W-1:0] exp);
      int t;
      t = 0;
      while (m_valid !== 1'b1 && t < 50) begin
         @(negedge clk);
         t++;
      end
      if (t == 50) begin
         err_total++;
         end_sim;
      end
      if (chk) `CHK("m_data", exp, m_data.count)
      m_ready = 1'b1;
      @(negedge clk);
      m_ready = 1'b0;
   endtask

   task automatic tb_window(input int cyc);
      nm = 0;
      ns = 0;
      na = 0;
      repeat (cyc) begin
         @(negedge clk);
         nm += (tb_en.mid === 1'b1);
         ns += (tb_en.slow === 1'b1);
         na += (aiao_tb_en === 1'b1);
      end
   endtask

   initial begin
      repeat (20) @(negedge clk);
      `CHK("m_valid", 1'b0, m_valid)
      `CHK("count", CNT_RST, count)
      nrst = 1'b1;
      tb_window(1600);
      `CHK("mid_pulses", 400, nm)
      `CHK("slow_pulses", 2, ns)
      `CHK("aiao_mid", 400, na)
      aiao_slow_sel = 1'b1;
      tb_window(1600);
      `CHK("aiao_slow", 2, na)
      foreach (rows[i]) begin
         bpcs_term_model_inst.src_pulses(rows[i].n, rows[i].hi);
         repeat (4) @(negedge clk);
         bpcs_term_model_inst.gate_pulse(2, 4);
         pop(1'b1, CNT_W'(rows[i].n));
      end
      `CHK("count", 32'h0000_000A, count)
      foreach (irows[i]) begin
         src_sel = irows[i].s;
         bpcs_term_model_inst.gate_pulse(2, irows[i].per - 3);
         bpcs_term_model_inst.gate_pulse(2, irows[i].per - 3);
         pop(1'b0, CNT_RST);
         pop(1'b1, CNT_W'(irows[i].exp));
      end
      // Flush the period that still counted slow timebase pulses
      src_sel = BPCS_SRC_EXT;
      bpcs_term_model_inst.gate_pulse(2, 4);
      pop(1'b0, CNT_RST);
      // Fill the buffer, then one gate edge too many
      repeat (16) bpcs_term_model_inst.gate_pulse(2, 2);
      `CHK("overrun", 0, n_ovr)
      bpcs_term_model_inst.gate_pulse(2, 4);
      `CHK("overrun", 1, n_ovr)
      repeat (16) pop(1'b1, CNT_RST);
      `CHK("m_valid", 1'b0, m_valid)
      `CHK("int_out", 1'b0, int_out)
      bpcs_term_model_inst.src_pulses(1, 1);
      nrst = 1'b0;
      @(negedge clk);
      `CHK("count", CNT_RST, count)
      end_sim;
   end
endmodule
